//--- rtl/bstp_pkg.sv
/*
 * Shared constants and types for the boundary-scan test port.
 * Assumes a single test port per device and a fixed boundary length.
 */
package bstp_pkg;

	// Instruction register layout
	localparam int BSTP_IR_W = 3;
	localparam logic [BSTP_IR_W-1:0] BSTP_IR_EXTEST = 3'h0;
	localparam logic [BSTP_IR_W-1:0] BSTP_IR_IDCODE = 3'h1;
	localparam logic [BSTP_IR_W-1:0] BSTP_IR_BYPASS = 3'h7;
	// Fixed low bits loaded on Capture-IR, as the standard demands
	localparam logic [BSTP_IR_W-1:0] BSTP_IR_CAPTURE = 3'h1;

	// Data register widths and reset values
	localparam int BSTP_ID_W = 32;
	localparam int BSTP_BSR_W = 8;
	localparam logic [BSTP_BSR_W-1:0] BSTP_BSR_RST = 8'h00;

	// Controller states, one-hot
	typedef enum logic [15:0] {
		BSTP_TLR = 16'h0001,
		BSTP_RTI = 16'h0002,
		BSTP_SEL_DR = 16'h0004,
		BSTP_CAP_DR = 16'h0008,
		BSTP_SH_DR = 16'h0010,
		BSTP_EX1_DR = 16'h0020,
		BSTP_PA_DR = 16'h0040,
		BSTP_EX2_DR = 16'h0080,
		BSTP_UPD_DR = 16'h0100,
		BSTP_SEL_IR = 16'h0200,
		BSTP_CAP_IR = 16'h0400,
		BSTP_SH_IR = 16'h0800,
		BSTP_EX1_IR = 16'h1000,
		BSTP_PA_IR = 16'h2000,
		BSTP_EX2_IR = 16'h4000,
		BSTP_UPD_IR = 16'h8000
	} bstp_state_e;

	// Serial pins sampled on the test clock
	typedef struct packed {
		logic test_state_select;
		logic test_serial_in;
	} bstp_pins_s;

	// State in the test clock domain (rising edge)
	typedef struct packed {
		bstp_state_e state;
		logic [BSTP_IR_W-1:0] ir;
		logic [BSTP_IR_W-1:0] ir_sh;
		logic [BSTP_ID_W-1:0] id_sh;
		logic byp;
		logic [BSTP_BSR_W-1:0] bsr;
		logic [BSTP_BSR_W-1:0] upd;
		logic upd_tgl;
	} bstp_tap_s;

	// State in the system clock domain
	typedef struct packed {
		logic [2:0] ext_sync;
		logic ext;
		logic [2:0] tgl_sync;
		logic tgl_seen;
		logic [BSTP_BSR_W-1:0] upd_hold;
		logic [BSTP_BSR_W-1:0] pins;
	} bstp_sys_s;

endpackage

//--- rtl/bstp_test_port.sv
/*
 * Boundary-scan test access port: sixteen-state controller, instruction
 * register, identification, bypass and boundary registers, and the
 * hand-off of boundary values to the pins in the system clock domain.
 * Assumes an external controller drives the test clock, mode select,
 * serial data and the active-low test reset; pads resolve the enable.
 */
`timescale 1ns/1ps

module bstp_test_port #(
	parameter logic [31:0] ID_CODE = 32'h0000_0001 // Arbitrary identification value
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic test_port_clock_in,
	input wire logic test_port_reset_n_in,
	input wire bstp_pkg::bstp_pins_s test_pins_in,
	output logic test_serial_out_out,
	output logic test_serial_out_oe_n_out,
	input wire logic [bstp_pkg::BSTP_BSR_W-1:0] core_pin_in,
	output logic [bstp_pkg::BSTP_BSR_W-1:0] pin_drive_out,
	output logic scan_extest_out
);
	import bstp_pkg::*;

	bstp_tap_s tap_reg;
	bstp_tap_s tap_next;
	bstp_sys_s sys_reg;
	bstp_sys_s sys_next;
	logic tdo_reg;
	logic tdo_oe_n_reg;
	logic tdo_src;
	logic shifting;
	logic extest_tck;

	// Standard controller step for one sampled mode select value
	function automatic bstp_state_e tap_step(input bstp_state_e s, input logic tms);
		bstp_state_e n;
		n = BSTP_TLR;
		unique case (s)
			BSTP_TLR: n = tms ? BSTP_TLR : BSTP_RTI;
			BSTP_RTI: n = tms ? BSTP_SEL_DR : BSTP_RTI;
			BSTP_SEL_DR: n = tms ? BSTP_SEL_IR : BSTP_CAP_DR;
			BSTP_CAP_DR: n = tms ? BSTP_EX1_DR : BSTP_SH_DR;
			BSTP_SH_DR: n = tms ? BSTP_EX1_DR : BSTP_SH_DR;
			BSTP_EX1_DR: n = tms ? BSTP_UPD_DR : BSTP_PA_DR;
			BSTP_PA_DR: n = tms ? BSTP_EX2_DR : BSTP_PA_DR;
			BSTP_EX2_DR: n = tms ? BSTP_UPD_DR : BSTP_SH_DR;
			BSTP_UPD_DR: n = tms ? BSTP_SEL_DR : BSTP_RTI;
			BSTP_SEL_IR: n = tms ? BSTP_TLR : BSTP_CAP_IR;
			BSTP_CAP_IR: n = tms ? BSTP_EX1_IR : BSTP_SH_IR;
			BSTP_SH_IR: n = tms ? BSTP_EX1_IR : BSTP_SH_IR;
			BSTP_EX1_IR: n = tms ? BSTP_UPD_IR : BSTP_PA_IR;
			BSTP_PA_IR: n = tms ? BSTP_EX2_IR : BSTP_PA_IR;
			BSTP_EX2_IR: n = tms ? BSTP_UPD_IR : BSTP_SH_IR;
			BSTP_UPD_IR: n = tms ? BSTP_SEL_DR : BSTP_RTI;
			// Corrupted one-hot code falls back to reset
			default: n = BSTP_TLR;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Test clock domain

	assign extest_tck = (tap_reg.ir == BSTP_IR_EXTEST);
	assign shifting = (tap_reg.state == BSTP_SH_IR) || (tap_reg.state == BSTP_SH_DR);

	// Serial output source; unknown instructions behave as bypass
	always_comb begin
		tdo_src = 1'b0;
		if (tap_reg.state == BSTP_SH_IR) begin
			tdo_src = tap_reg.ir_sh[0];
		end else if (tap_reg.state == BSTP_SH_DR) begin
			if (tap_reg.ir == BSTP_IR_IDCODE) begin
				tdo_src = tap_reg.id_sh[0];
			end else if (extest_tck) begin
				tdo_src = tap_reg.bsr[0];
			end else begin
				tdo_src = tap_reg.byp;
			end
		end
	end

	// Next state of the scan chain and controller
	always_comb begin
		tap_next = tap_reg;
		tap_next.state = tap_step(tap_reg.state, test_pins_in.test_state_select);
		unique case (tap_reg.state)
			BSTP_TLR: begin
				tap_next.ir = BSTP_IR_IDCODE;
			end
			BSTP_CAP_IR: begin
				tap_next.ir_sh = BSTP_IR_CAPTURE;
			end
			BSTP_SH_IR: begin
				tap_next.ir_sh = {test_pins_in.test_serial_in, tap_reg.ir_sh[BSTP_IR_W-1:1]};
			end
			BSTP_UPD_IR: begin
				tap_next.ir = tap_reg.ir_sh;
			end
			BSTP_CAP_DR: begin
				tap_next.id_sh = ID_CODE;
				tap_next.byp = 1'b0;
				// Captures the held drive values, so a read-back shows what is applied
				tap_next.bsr = tap_reg.upd;
			end
			BSTP_SH_DR: begin
				if (tap_reg.ir == BSTP_IR_IDCODE) begin
					tap_next.id_sh = {test_pins_in.test_serial_in, tap_reg.id_sh[BSTP_ID_W-1:1]};
				end else if (extest_tck) begin
					tap_next.bsr = {test_pins_in.test_serial_in, tap_reg.bsr[BSTP_BSR_W-1:1]};
				end else begin
					tap_next.byp = test_pins_in.test_serial_in;
				end
			end
			BSTP_UPD_DR: begin
				if (extest_tck) begin
					tap_next.upd = tap_reg.bsr;
					// Toggle tells the system side a new word is stable
					tap_next.upd_tgl = ~tap_reg.upd_tgl;
				end
			end
			default: begin
			end
		endcase
	end

	// Asynchronous test reset: constants only
	always_ff @(posedge test_port_clock_in or negedge test_port_reset_n_in) begin
		if (!test_port_reset_n_in) begin
			tap_reg.state <= BSTP_TLR;
			tap_reg.ir <= BSTP_IR_IDCODE;
			tap_reg.ir_sh <= BSTP_IR_CAPTURE;
			tap_reg.id_sh <= '0;
			tap_reg.byp <= 1'b0;
			tap_reg.bsr <= BSTP_BSR_RST;
			tap_reg.upd <= BSTP_BSR_RST;
			tap_reg.upd_tgl <= 1'b0;
		end else begin
			tap_reg <= tap_next;
		end
	end

	// Falling-edge output stage; enable is low only while shifting
	always_ff @(negedge test_port_clock_in or negedge test_port_reset_n_in) begin
		if (!test_port_reset_n_in) begin
			tdo_reg <= 1'b0;
			tdo_oe_n_reg <= 1'b1;
		end else begin
			tdo_reg <= tdo_src;
			tdo_oe_n_reg <= ~shifting;
		end
	end

	assign test_serial_out_out = tdo_reg;
	assign test_serial_out_oe_n_out = tdo_oe_n_reg;

	////////////////////////////////////////////////////////////////////////////
	// System clock domain

	// Three-stage synchronisers; only stages two and three are compared
	always_comb begin
		sys_next = sys_reg;
		sys_next.ext_sync = {sys_reg.ext_sync[1:0], extest_tck & test_port_reset_n_in};
		sys_next.tgl_sync = {sys_reg.tgl_sync[1:0], tap_reg.upd_tgl};
		if (sys_reg.ext_sync[1] == sys_reg.ext_sync[2]) begin
			sys_next.ext = sys_reg.ext_sync[2];
		end
		// Held word is stable for many system cycles after the toggle
		if ((sys_reg.tgl_sync[1] == sys_reg.tgl_sync[2]) &&
			(sys_reg.tgl_sync[2] != sys_reg.tgl_seen)) begin
			sys_next.tgl_seen = sys_reg.tgl_sync[2];
			sys_next.upd_hold = tap_reg.upd;
		end
		// Pins follow the core unless boundary drive is active
		sys_next.pins = sys_reg.ext ? sys_reg.upd_hold : core_pin_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sys_reg.ext_sync <= 3'h0;
			sys_reg.ext <= 1'b0;
			sys_reg.tgl_sync <= 3'h0;
			sys_reg.tgl_seen <= 1'b0;
			sys_reg.upd_hold <= BSTP_BSR_RST;
			sys_reg.pins <= BSTP_BSR_RST;
		end else begin
			sys_reg <= sys_next;
		end
	end

	assign pin_drive_out = sys_reg.pins;
	assign scan_extest_out = sys_reg.ext;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_async_reset;
		@(posedge test_port_clock_in)
		!test_port_reset_n_in |-> (tap_reg.state == BSTP_TLR);
	endproperty
	a_async_reset: assert property (p_async_reset) else $error("controller not reset");

	property p_id_after_reset;
		@(posedge test_port_clock_in)
		$rose(test_port_reset_n_in) |-> (tap_reg.ir == BSTP_IR_IDCODE) && (tap_reg.state == BSTP_TLR);
	endproperty
	a_id_after_reset: assert property (p_id_after_reset) else $error("no id state on release");

	property p_normal_pins;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!sys_reg.ext |=> (pin_drive_out == $past(core_pin_in));
	endproperty
	a_normal_pins: assert property (p_normal_pins) else $error("pins not following core");

	property p_capture_in;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		(tap_reg.state == BSTP_SH_IR) |=>
			(tap_reg.ir_sh[BSTP_IR_W-1] == $past(test_pins_in.test_serial_in));
	endproperty
	a_capture_in: assert property (p_capture_in) else $error("serial input not taken");

	property p_out_falling;
		@(negedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		shifting |=> !test_serial_out_oe_n_out && (test_serial_out_out == $past(tdo_src));
	endproperty
	a_out_falling: assert property (p_out_falling) else $error("serial output wrong");

	property p_float_idle;
		@(negedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		!shifting |=> test_serial_out_oe_n_out;
	endproperty
	a_float_idle: assert property (p_float_idle) else $error("output driven while idle");

	property p_step;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		(tap_reg.state == BSTP_RTI) && test_pins_in.test_state_select |=>
			(tap_reg.state == BSTP_SEL_DR);
	endproperty
	a_step: assert property (p_step) else $error("bad state step");

	property p_five_high;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		test_pins_in.test_state_select [*5] |=> (tap_reg.state == BSTP_TLR);
	endproperty
	a_five_high: assert property (p_five_high) else $error("no reset after five highs");

	// Sitting in reset keeps identification selected
	property p_tlr_ir;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		(tap_reg.state == BSTP_TLR) |=> (tap_reg.ir == BSTP_IR_IDCODE);
	endproperty
	a_tlr_ir: assert property (p_tlr_ir) else $error("identification not selected");

	// Instruction capture loads the fixed pattern
	property p_ir_capture;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		(tap_reg.state == BSTP_CAP_IR) |=> (tap_reg.ir_sh == BSTP_IR_CAPTURE);
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("bad instruction capture");

	// Update moves the shifted instruction into use
	property p_ir_update;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		(tap_reg.state == BSTP_UPD_IR) |=> (tap_reg.ir == $past(tap_reg.ir_sh));
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

	// Data capture loads identification and clears bypass
	property p_dr_capture;
		@(posedge test_port_clock_in) disable iff (!test_port_reset_n_in)
		(tap_reg.state == BSTP_CAP_DR) |=> (tap_reg.id_sh == ID_CODE) && !tap_reg.byp;
	endproperty
	a_dr_capture: assert property (p_dr_capture) else $error("bad data capture");

	// Held-low test reset must end boundary drive within the synchroniser delay
	property p_reset_ext;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!test_port_reset_n_in [*5] |-> !scan_extest_out;
	endproperty
	a_reset_ext: assert property (p_reset_ext) else $error("drive active in test reset");

	// Boundary drive shows the held word, never the core
	property p_ext_pins;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		sys_reg.ext |=> (pin_drive_out == $past(sys_reg.upd_hold));
	endproperty
	a_ext_pins: assert property (p_ext_pins) else $error("pins not from held word");

	c_ir_update: cover property (@(posedge test_port_clock_in) tap_reg.state == BSTP_UPD_IR);
	c_id_shift: cover property (@(posedge test_port_clock_in)
		(tap_reg.state == BSTP_SH_DR) && (tap_reg.ir == BSTP_IR_IDCODE));
	c_extest: cover property (@(posedge clk_sys_in) $rose(sys_reg.ext));
	c_pin_load: cover property (@(posedge clk_sys_in) sys_reg.ext && $changed(sys_reg.upd_hold));
	c_reset_clock: cover property (@(posedge test_port_clock_in) !test_port_reset_n_in);

endmodule

//--- test/bstp_ctrl_model.sv
/*
 * Model of the external boundary-scan controller that drives the test port.
 * Assumes the device splits serial out into data and an active-low enable.
 */
`timescale 1ns/1ps

module bstp_ctrl_model (
	output logic test_port_clock_out,
	output logic test_port_reset_n_out,
	output bstp_pkg::bstp_pins_s test_pins_out,
	input wire logic test_serial_out_in,
	input wire logic test_serial_out_oe_n_in
);
	import bstp_pkg::*;

	logic line_last = 1'h0;
	logic oe_seen;
	wire logic tdo_line;

	// Floating line reads inverted, so a stale bit never passes
	assign tdo_line = test_serial_out_oe_n_in ? ~line_last : test_serial_out_in;

	// Last level the device really drove
	always @(posedge test_port_clock_out) begin
		if (test_serial_out_oe_n_in === 1'h0) begin
			line_last <= test_serial_out_in;
		end
	end

	// Test reset held low and clock still until scans begin
	initial begin
		test_port_clock_out = 1'h0;
		test_pins_out = 2'h3;
		// Brief high so the test reset sees a real falling edge
		test_port_reset_n_out = 1'h1;
		#1;
		test_port_reset_n_out = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////////

	// Test reset level, applied with the clock standing still
	task automatic set_reset(input logic v);
		test_port_reset_n_out = v;
	endtask

	// One test clock; inputs set while low, line sampled at the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		test_pins_out.test_state_select = tms;
		test_pins_out.test_serial_in = tdi;
		#62.5;
		tdo = tdo_line;
		oe_seen = test_serial_out_oe_n_in;
		test_port_clock_out = 1'h1;
		#62.5;
		test_port_clock_out = 1'h0;
	endtask

	// Five highs on mode select
	task automatic to_reset();
		logic b;
		repeat (5) step(1'h1, 1'h1, b);
	endtask

	// Full scan from idle, LSB first, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout, output logic en_ok);
		logic b;
		dout = 32'h0;
		en_ok = 1'h1;
		step(1'h1, 1'h1, b);
		if (ir) begin
			step(1'h1, 1'h1, b);
		end
		step(1'h0, 1'h1, b);
		step(1'h0, 1'h1, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
			en_ok &= (oe_seen === 1'h0);
		end
		step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
	endtask
endmodule

//--- test/bstp_test_port_tb.sv
/*
 * Self-checking bench for the boundary-scan test port.
 * Assumes the controller model supplies the test clock and serial pins.
 */
`timescale 1ns/1ps

module bstp_test_port_tb;
	import bstp_pkg::*;

	localparam logic [31:0] ID_VAL = 32'h5A3C0F01; // Arbitrary identification value
	logic clk_sys_in = 1'h0;
	logic rst_n_in;
	logic [BSTP_BSR_W-1:0] core_pin_in;
	logic [BSTP_BSR_W-1:0] pin_drive_out;
	logic scan_extest_out, tck, trst_n, tdo, oe_n, en_ok, b;
	bstp_pins_s pins;
	logic [2:0] codes [3] = '{BSTP_IR_IDCODE, BSTP_IR_BYPASS, 3'h3};
	logic [31:0] dout, din, word, prev;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed;

	bstp_test_port #(.ID_CODE(ID_VAL)) uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.test_port_clock_in(tck), .test_port_reset_n_in(trst_n), .test_pins_in(pins),
		.test_serial_out_out(tdo), .test_serial_out_oe_n_out(oe_n),
		.core_pin_in(core_pin_in), .pin_drive_out(pin_drive_out),
		.scan_extest_out(scan_extest_out));

	bstp_ctrl_model ctrl (.test_port_clock_out(tck), .test_port_reset_n_out(trst_n),
		.test_pins_out(pins), .test_serial_out_in(tdo), .test_serial_out_oe_n_in(oe_n));

	// System clock and a ceiling on the run
	always #5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Compare and report
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Identification returns the code; anything else acts as bypass
	function automatic logic [31:0] exp_dr(input logic [2:0] code, input logic [31:0] d);
		return (code == BSTP_IR_IDCODE) ? ID_VAL : {d[30:0], 1'h0};
	endfunction

	task automatic read_id();
		ctrl.step(1'h0, 1'h1, b);
		ctrl.scan(1'h0, 32, 32'($random(seed)), dout, en_ok);
		check("idcode", dout, ID_VAL);
	endtask

	task automatic pins_follow();
		@(negedge clk_sys_in);
		core_pin_in = 8'($random(seed));
		@(negedge clk_sys_in);
		check("pins", 32'(pin_drive_out), 32'(core_pin_in));
	endtask

	// Main sequence
	initial begin
		seed = 72240;
		rst_n_in = 1'h0;
		core_pin_in = 8'h0;
		repeat (4) @(negedge clk_sys_in);
		rst_n_in = 1'h1;
		check("oe_n reset", 32'(oe_n), 32'h1);
		repeat (4) pins_follow();
		ctrl.set_reset(1'h1);
		read_id();
		check("oe_n shift", 32'(en_ok), 32'h1);
		check("oe_n idle", 32'(oe_n), 32'h1);
		foreach (codes[i]) begin
			ctrl.scan(1'h1, 3, 32'(codes[i]), dout, en_ok);
			check("ir capture", dout, 32'(BSTP_IR_CAPTURE));
			din = $random(seed);
			ctrl.scan(1'h0, 32, din, dout, en_ok);
			check("dr shift", dout, exp_dr(codes[i], din));
		end
		ctrl.scan(1'h1, 3, 32'(BSTP_IR_EXTEST), dout, en_ok);
		repeat (8) @(negedge clk_sys_in);
		check("extest", 32'(scan_extest_out), 32'h1);
		for (int k = 0; k < 2; k++) begin
			word = 32'($random(seed) & 32'hFF);
			ctrl.scan(1'h0, 8, word, dout, en_ok);
			if (k == 1) check("capture", dout, prev);
			prev = word;
			@(negedge clk_sys_in);
			core_pin_in = 8'($random(seed));
			repeat (8) @(negedge clk_sys_in);
			check("drive", 32'(pin_drive_out), word);
		end
		ctrl.to_reset();
		repeat (8) @(negedge clk_sys_in);
		check("extest off", 32'(scan_extest_out), 32'h0);
		read_id();
		// Test reset dropped in mid-shift, with no test clock
		ctrl.scan(1'h1, 3, 32'(BSTP_IR_EXTEST), dout, en_ok);
		ctrl.step(1'h1, 1'h1, b);
		ctrl.step(1'h0, 1'h1, b);
		ctrl.step(1'h0, 1'h1, b);
		#1;
		check("oe_n shift", 32'(oe_n), 32'h0);
		ctrl.set_reset(1'h0);
		#1;
		check("oe_n async", 32'(oe_n), 32'h1);
		// Test clock keeps running while reset is held
		ctrl.step(1'h1, 1'h1, b);
		ctrl.step(1'h1, 1'h1, b);
		repeat (8) @(negedge clk_sys_in);
		check("extest reset", 32'(scan_extest_out), 32'h0);
		pins_follow();
		ctrl.set_reset(1'h1);
		read_id();
		end_of_test();
	end
endmodule
